// ==== sbtc_core.sv ====
// Processor-side system bus master/slave sequencer with tertiary cache control.
// Assumes all pins are synchronous to clk; bidirectional pins are resolved by the surroundings.
`timescale 1ns/100ps
`default_nettype none
`include "sbtc_map.svh"

module sbtc_core (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Boot straps, caught once after reset
   input wire logic mode_two_reads,
   input wire logic mode_l3_enable,
   // Core request port
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_instr,
   input wire logic [`SBTC_BUS_W-1:0] req_addr,
   input wire logic [`SBTC_BUS_W-1:0] req_wdata,
   // Core return port
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic [`SBTC_BUS_W-1:0] rsp_data,
   output logic rsp_slot,
   // Maintenance
   input wire logic l3_clear_req,
   input wire logic par_err_clear,
   output logic par_err,
   // System bus handshakes
   input wire logic agent_request_n,
   output logic release_n,
   input wire logic read_accept_n,
   input wire logic write_accept_n,
   input wire logic inbound_valid_n,
   output logic outbound_valid_n,
   output logic cpu_bus_request_n,
   input wire logic cpu_bus_grant_n,
   input wire logic return_order_swap_n,
   output logic read_kind,
   // Shared address/data bus and parity
   input wire logic [`SBTC_BUS_W-1:0] shared_addr_data_bus_in,
   output logic [`SBTC_BUS_W-1:0] shared_addr_data_bus_out,
   output logic shared_addr_data_bus_oe,
   input wire logic [`SBTC_PAR_W-1:0] shared_bus_parity_in,
   output logic [`SBTC_PAR_W-1:0] shared_bus_parity_out,
   output logic shared_bus_parity_oe,
   // Command bus and parity
   input wire logic [`SBTC_CMD_W-1:0] command_id_bus_in,
   output logic [`SBTC_CMD_W-1:0] command_id_bus_out,
   output logic command_id_bus_oe,
   input wire logic command_bus_parity_in,
   output logic command_bus_parity_out,
   output logic command_bus_parity_oe,
   // Tertiary cache
   output logic l3_block_clear_n,
   output logic [1:0] l3_write_enable_n,
   output logic [1:0] l3_data_chip_enable_n,
   input wire logic l3_data_output_enable_n,
   output logic [`SBTC_LINE_W-1:0] l3_line_index,
   input wire logic l3_tag_hit,
   output logic l3_tag_chip_enable_n,
   output logic l3_tag_latch_enable_n,
   output logic l3_tag_output_enable_n,
   input wire logic [1:0] l3_doubleword_index_in,
   output logic [1:0] l3_doubleword_index_out,
   output logic l3_doubleword_index_oe,
   input wire logic l3_line_valid_in,
   output logic l3_line_valid_out,
   output logic l3_line_valid_oe
);
   import sbtc_pkg::*;

   // ==========================================================
   // Constants
   localparam int SW = 8 + `SBTC_PAR_W + `SBTC_BUS_W;
   localparam int FD = `SBTC_FIFO_DEPTH;
   localparam logic [$clog2(FD)+1:0] ROOM = ($clog2(FD)+2)'(FD - `SBTC_FIFO_RESERVE);
   localparam sbtc_core_type CORE_RST = '{
      st: ST_IDLE,
      release_n: `SBTC_NEG,
      out_valid_n: `SBTC_NEG,
      bus_req_n: `SBTC_NEG,
      tag_ce_n: `SBTC_NEG,
      tag_de_n: `SBTC_NEG,
      tag_oe_n: `SBTC_NEG,
      clear_n: `SBTC_NEG,
      we_n: 2'h3,
      dce_n: 2'h3,
      default: '0
   };

   // ==========================================================
   // Pin synchronisers
   logic [SW-1:0] sync_d;
   logic [SW-1:0] sync_q;
   logic agent_req_s;
   logic rd_acc_s;
   logic wr_acc_s;
   logic in_valid_s;
   logic grant_s;
   logic swap_s;
   logic dout_en_s;
   logic hit_s;
   logic [`SBTC_PAR_W-1:0] par_s;
   logic [`SBTC_BUS_W-1:0] bus_s;

   assign sync_d = {agent_request_n, read_accept_n, write_accept_n, inbound_valid_n, cpu_bus_grant_n,
                    return_order_swap_n, l3_data_output_enable_n, l3_tag_hit, shared_bus_parity_in,
                    shared_addr_data_bus_in};
   assign {agent_req_s, rd_acc_s, wr_acc_s, in_valid_s, grant_s, swap_s, dout_en_s, hit_s, par_s, bus_s} = sync_q;

   sbtc_sync #(
      .W(SW),
      .INIT({7'h7f, {(SW-7){1'b0}}})
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(sync_d),
      .q(sync_q)
   );

   // ==========================================================
   // Return FIFO
   sbtc_core_type r;
   sbtc_core_type r_nxt;
   logic fifo_in_ready;
   logic [$clog2(FD)+1:0] fifo_level;
   logic [`SBTC_BUS_W:0] fifo_out;

   sbtc_fifo #(
      .W(`SBTC_BUS_W + 1),
      .DEPTH(FD)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(r.push),
      .in_ready(fifo_in_ready),
      .in_data(r.push_data),
      .out_valid(rsp_valid),
      .out_ready(rsp_ready),
      .out_data(fifo_out),
      .level(fifo_level)
   );

   assign rsp_slot = fifo_out[`SBTC_BUS_W];
   assign rsp_data = fifo_out[`SBTC_BUS_W-1:0];

   // ==========================================================
   // Byte parity, even, one bit per byte lane
   logic [`SBTC_PAR_W-1:0] par_w;
   logic [`SBTC_PAR_W-1:0] par_in_calc;

   for (genvar i = 0; i < `SBTC_PAR_W; i++) begin : g_par
      assign par_w[i] = ^r.wdata[8*i +: 8];
      assign par_in_calc[i] = ^bus_s[8*i +: 8];
   end

   // ==========================================================
   // Sequencer
   logic ret;
   logic inbound;
   logic room;

   // Slot the agent will answer next
   assign ret = (&r.pend) ? r.order : r.pend[1];
   assign inbound = !in_valid_s && (r.pend != 2'h0) && (r.st == ST_SLAVE || r.st == ST_REGAIN);
   // Reserve space for two full lines so the agent never has to be stalled
   assign room = fifo_in_ready && (fifo_level <= ROOM);

   always_comb begin
      r_nxt = r;
      r_nxt.release_n = 1'b1;
      r_nxt.out_valid_n = 1'b1;
      r_nxt.bus_req_n = 1'b1;
      r_nxt.bus_oe = 1'b0;
      r_nxt.par_oe = 1'b0;
      r_nxt.cmd_oe = 1'b0;
      r_nxt.cmd_par = 1'b0;
      r_nxt.tag_ce_n = 1'b1;
      r_nxt.tag_de_n = 1'b1;
      r_nxt.tag_oe_n = 1'b1;
      r_nxt.clear_n = 1'b1;
      r_nxt.we_n = 2'h3;
      r_nxt.dce_n = 2'h3;
      r_nxt.word_oe = 1'b0;
      r_nxt.valid_oe = 1'b0;
      r_nxt.push = 1'b0;
      r_nxt.req_ready = 1'b0;
      r_nxt.cap_sr = {r.cap_sr[2:0], 1'b0};

      if (!r.straps_taken) begin
         r_nxt.straps_taken = 1'b1;
         r_nxt.mode_two = mode_two_reads;
         r_nxt.mode_l3 = mode_l3_enable;
      end

      // Each asserted cycle flips the expected order while both reads are open
      if (r.mode_two && !swap_s && (&r.pend)) begin
         r_nxt.order = ~r.order;
      end

      // Hit data returned by the data RAMs
      if (r.cap_sr[3]) begin
         r_nxt.push = 1'b1;
         r_nxt.push_data = {r.cur, bus_s};
      end

      // Set wins over a clear in the same cycle
      if (par_err_clear) begin
         r_nxt.par_err = 1'b0;
      end
      if (inbound && (par_s != par_in_calc)) begin
         r_nxt.par_err = 1'b1;
      end

      // Refill beats from the agent
      if (inbound) begin
         r_nxt.push = 1'b1;
         r_nxt.push_data = {ret, bus_s};
         r_nxt.beat = r.beat + 2'h1;
         if (r.mode_l3) begin
            r_nxt.line = r.slot_line[ret];
            r_nxt.dce_n = 2'h0;
            if (dout_en_s) begin
               r_nxt.we_n = 2'h0;
            end
         end
         if (r.beat == `SBTC_BEATS_LAST) begin
            r_nxt.pend[ret] = 1'b0;
            r_nxt.beat = 2'h0;
            if (r.mode_l3) begin
               r_nxt.tag_ce_n = 1'b0;
               r_nxt.valid_out = 1'b1;
               r_nxt.valid_oe = 1'b1;
            end
         end
      end

      unique case (r.st)
         ST_IDLE: begin
            if (req_valid && r.req_ready) begin
               r_nxt.bus_out = req_addr;
               r_nxt.bus_oe = 1'b1;
               r_nxt.cmd_oe = 1'b1;
               r_nxt.out_valid_n = 1'b0;
               if (req_write) begin
                  r_nxt.cmd_out = `SBTC_CMD_WRITE;
                  r_nxt.wdata = req_wdata;
                  r_nxt.st = ST_WDATA;
               end else begin
                  r_nxt.cmd_out = `SBTC_CMD_READ | {8'h00, r.alloc};
                  r_nxt.read_kind = req_instr;
                  r_nxt.cur = r.alloc;
                  r_nxt.alloc = ~r.alloc;
                  r_nxt.pend[r.alloc] = 1'b1;
                  r_nxt.slot_line[r.alloc] = req_addr[`SBTC_LINE_LSB +: `SBTC_LINE_W];
                  if (r.pend != 2'h0) begin
                     r_nxt.order = ~r.alloc;
                  end
                  if (r.mode_l3) begin
                     r_nxt.tag_ce_n = 1'b0;
                     r_nxt.tag_de_n = 1'b0;
                     r_nxt.line = req_addr[`SBTC_LINE_LSB +: `SBTC_LINE_W];
                     r_nxt.cnt = `SBTC_HIT_WAIT;
                     r_nxt.st = ST_CHECK;
                  end else begin
                     r_nxt.st = ST_RELEASE;
                  end
               end
            end else if (!agent_req_s && r.pend == 2'h0) begin
               r_nxt.st = ST_RELEASE;
            end else if (l3_clear_req && r.mode_l3) begin
               r_nxt.clear_n = 1'b0;
            end
            // Offer the next request only from a quiet master state
            if (r_nxt.st == ST_IDLE && r.straps_taken && agent_req_s && !(req_valid && r.req_ready)) begin
               if (req_write) begin
                  r_nxt.req_ready = !wr_acc_s && (r.pend == 2'h0);
               end else begin
                  r_nxt.req_ready = !rd_acc_s && room && !(&r.pend);
               end
            end
         end
         ST_WDATA: begin
            r_nxt.bus_out = r.wdata;
            r_nxt.par_out = par_w;
            r_nxt.cmd_out = `SBTC_CMD_DATA;
            r_nxt.bus_oe = 1'b1;
            r_nxt.par_oe = 1'b1;
            r_nxt.cmd_oe = 1'b1;
            r_nxt.out_valid_n = 1'b0;
            r_nxt.st = ST_IDLE;
         end
         ST_CHECK: begin
            r_nxt.cnt = r.cnt - 2'h1;
            if (r.cnt == 2'h0) begin
               r_nxt.beat = 2'h0;
               r_nxt.cnt = 2'h0;
               r_nxt.st = hit_s ? ST_HITRD : ST_RELEASE;
            end
         end
         ST_HITRD: begin
            if (!r.cnt[0]) begin
               r_nxt.dce_n = 2'h0;
               r_nxt.word_out = r.beat;
               r_nxt.word_oe = 1'b1;
               r_nxt.cap_sr[0] = 1'b1;
               r_nxt.beat = r.beat + 2'h1;
               if (r.beat == `SBTC_BEATS_LAST) begin
                  r_nxt.cnt = 2'h1;
               end
            end else if (r.cap_sr == 4'h0) begin
               r_nxt.pend[r.cur] = 1'b0;
               r_nxt.cnt = 2'h0;
               r_nxt.beat = 2'h0;
               r_nxt.st = ST_IDLE;
            end
         end
         ST_RELEASE: begin
            r_nxt.release_n = 1'b0;
            r_nxt.beat = 2'h0;
            r_nxt.st = ST_SLAVE;
         end
         ST_SLAVE: begin
            if (r.mode_two && (r_nxt.pend == 2'h1 || r_nxt.pend == 2'h2) && req_valid && !req_write) begin
               r_nxt.st = ST_REGAIN;
            end else if (r_nxt.pend == 2'h0 && agent_req_s) begin
               r_nxt.st = ST_IDLE;
            end
         end
         ST_REGAIN: begin
            if (!grant_s) begin
               r_nxt.st = ST_IDLE;
            end else begin
               r_nxt.bus_req_n = 1'b0;
            end
         end
         default: begin
            r_nxt = CORE_RST;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= CORE_RST;
      end else begin
         r <= r_nxt;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state register
   assign req_ready = r.req_ready;
   assign par_err = r.par_err;
   assign release_n = r.release_n;
   assign outbound_valid_n = r.out_valid_n;
   assign cpu_bus_request_n = r.bus_req_n;
   assign read_kind = r.read_kind;
   assign shared_addr_data_bus_out = r.bus_out;
   assign shared_addr_data_bus_oe = r.bus_oe;
   assign shared_bus_parity_out = r.par_out;
   assign shared_bus_parity_oe = r.par_oe;
   assign command_id_bus_out = r.cmd_out;
   assign command_id_bus_oe = r.cmd_oe;
   assign command_bus_parity_out = r.cmd_par;
   assign command_bus_parity_oe = r.cmd_oe;
   assign l3_block_clear_n = r.clear_n;
   assign l3_write_enable_n = r.we_n;
   assign l3_data_chip_enable_n = r.dce_n;
   assign l3_line_index = r.line;
   assign l3_tag_chip_enable_n = r.tag_ce_n;
   assign l3_tag_latch_enable_n = r.tag_de_n;
   assign l3_tag_output_enable_n = r.tag_oe_n;
   assign l3_doubleword_index_out = r.word_out;
   assign l3_doubleword_index_oe = r.word_oe;
   assign l3_line_valid_out = r.valid_out;
   assign l3_line_valid_oe = r.valid_oe;

endmodule
`default_nettype wire

// ==== sbtc_map.svh ====
// Constants of the system bus and tertiary cache interface: opcodes, field positions, counts.
// Assumes inclusion by its bare name from the package and the design modules.
`ifndef SBTC_MAP_SVH
`define SBTC_MAP_SVH

// ==========================================================
// Command encodings
`define SBTC_CMD_READ 9'h000
`define SBTC_CMD_WRITE 9'h080
`define SBTC_CMD_DATA 9'h100

// ==========================================================
// Field positions
`define SBTC_LINE_LSB 5
`define SBTC_LINE_W 18
`define SBTC_BUS_W 64
`define SBTC_CMD_W 9
`define SBTC_PAR_W 8

// ==========================================================
// Reset values and timing counts
`define SBTC_NEG 1'b1
`define SBTC_BEATS_LAST 2'h3
`define SBTC_HIT_WAIT 2'h3
`define SBTC_FIFO_DEPTH 16
`define SBTC_FIFO_RESERVE 8

`endif

// ==== sbtc_pkg.sv ====
// Types shared by the system bus and tertiary cache interface.
// Assumes sbtc_map.svh sits in the same folder.
`include "sbtc_map.svh"

package sbtc_pkg;

   // ==========================================================
   // Sequencer states, Gray along idle-check-release-slave-regain
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CHECK = 3'h1,
      ST_RELEASE = 3'h3,
      ST_SLAVE = 3'h2,
      ST_REGAIN = 3'h6,
      ST_WDATA = 3'h4,
      ST_HITRD = 3'h5
   } sbtc_state_type;

   // ==========================================================
   // Whole state of the interface core
   typedef struct packed {
      sbtc_state_type st;
      logic [1:0] cnt;
      logic [1:0] beat;
      logic [3:0] cap_sr;
      logic [1:0] pend;
      logic order;
      logic alloc;
      logic cur;
      logic [1:0][`SBTC_LINE_W-1:0] slot_line;
      logic straps_taken;
      logic mode_two;
      logic mode_l3;
      logic req_ready;
      logic release_n;
      logic out_valid_n;
      logic read_kind;
      logic bus_req_n;
      logic [`SBTC_BUS_W-1:0] bus_out;
      logic bus_oe;
      logic [`SBTC_PAR_W-1:0] par_out;
      logic par_oe;
      logic [`SBTC_CMD_W-1:0] cmd_out;
      logic cmd_oe;
      logic cmd_par;
      logic [`SBTC_BUS_W-1:0] wdata;
      logic tag_ce_n;
      logic tag_de_n;
      logic tag_oe_n;
      logic clear_n;
      logic [1:0] we_n;
      logic [1:0] dce_n;
      logic [`SBTC_LINE_W-1:0] line;
      logic [1:0] word_out;
      logic word_oe;
      logic valid_out;
      logic valid_oe;
      logic push;
      logic [`SBTC_BUS_W:0] push_data;
      logic par_err;
   } sbtc_core_type;

endpackage

// ==== sbtc_sync.sv ====
// Two-flop synchroniser bank for pin inputs.
// Assumes each bit is independent; buses are only read when their valid qualifier is stable.
`timescale 1ns/100ps
`default_nettype none

module sbtc_sync #(
   parameter int W = 8,
   // Idle level of each pin, loaded at reset so no false edge follows it
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } sbtc_sync_type;

   sbtc_sync_type r;
   sbtc_sync_type r_nxt;

   if (W < 1) begin : g_chk
      $error("sbtc_sync width must be at least one");
   end

   // The first stage feeds the second stage only
   always_comb begin
      r_nxt.meta = d;
      r_nxt.sync = r.meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= {INIT, INIT};
      end else begin
         r <= r_nxt;
      end
   end

   assign q = r.sync;

endmodule
`default_nettype wire

// ==== sbtc_fifo.sv ====
// Return-data FIFO with registered read port and back-pressure on both sides.
// Assumes a power-of-two depth; level counts the output register too.
`timescale 1ns/100ps
`default_nettype none

module sbtc_fifo #(
   parameter int W = 65,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   // Occupancy
   output logic [$clog2(DEPTH)+1:0] level
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ov;
      logic [W-1:0] od;
   } sbtc_fifo_type;

   sbtc_fifo_type r;
   sbtc_fifo_type r_nxt;
   logic wr;
   logic rd;

   if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_chk
      $error("sbtc_fifo needs a power-of-two depth of two or more");
   end

   assign in_ready = (r.cnt != DEPTH[AW:0]);
   assign wr = in_valid && in_ready;
   // Refill the output register whenever it is empty or being taken
   assign rd = (r.cnt != '0) && (!r.ov || out_ready);

   always_comb begin
      r_nxt = r;
      if (wr) begin
         r_nxt.mem[r.wp] = in_data;
         r_nxt.wp = r.wp + 1'b1;
      end
      if (rd) begin
         r_nxt.od = r.mem[r.rp];
         r_nxt.rp = r.rp + 1'b1;
         r_nxt.ov = 1'b1;
      end else if (out_ready) begin
         r_nxt.ov = 1'b0;
      end
      r_nxt.cnt = r.cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign out_valid = r.ov;
   assign out_data = r.od;
   assign level = {1'b0, r.cnt} + {{(AW+1){1'b0}}, r.ov};

endmodule
`default_nettype wire

// ==== sbtc_core_end.sv ====
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ==== sbtc_core_assertions.sv ====
// Pin checks for sbtc_core, attached by bind.
// Assumes one clock and an async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module sbtc_core_assertions (
   // Clock, reset
   input wire logic clk,
   input wire logic rst_n,
   // Request port
   input wire logic req_valid,
   input wire logic req_ready,
   // System bus
   input wire logic release_n,
   input wire logic outbound_valid_n,
   input wire logic [63:0] shared_addr_data_bus_out,
   input wire logic [7:0] shared_bus_parity_out,
   input wire logic [8:0] command_id_bus_out,
   input wire logic command_id_bus_oe,
   input wire logic command_bus_parity_out,
   // Tertiary cache
   input wire logic [1:0] l3_write_enable_n,
   input wire logic [1:0] l3_data_chip_enable_n,
   input wire logic l3_tag_output_enable_n
);
   logic [7:0] par_w;
   // ====================
   // Checks
   always_comb begin
      for (int i = 0; i < 8; i++)
         par_w[i] = ^shared_addr_data_bus_out[8*i+:8];
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   property p_taken; req_valid && req_ready |=> !outbound_valid_n; endproperty
   a_taken: assert property (p_taken) else $error("no address cycle");
   property p_drive; !outbound_valid_n |-> command_id_bus_oe; endproperty
   a_drive: assert property (p_drive) else $error("valid without drive");
   property p_cmd_par; command_id_bus_oe |-> !command_bus_parity_out; endproperty
   a_cmd_par: assert property (p_cmd_par) else $error("command parity high");
   property p_data_par; !outbound_valid_n && command_id_bus_out == 9'h100 |-> shared_bus_parity_out == par_w; endproperty
   a_data_par: assert property (p_data_par) else $error("bad data parity");
   property p_rel; $fell(release_n) |=> $rose(release_n); endproperty
   a_rel: assert property (p_rel) else $error("release not one cycle");
   property p_we; l3_write_enable_n[0] == l3_write_enable_n[1]; endproperty
   a_we: assert property (p_we) else $error("write enable copies differ");
   property p_ce; l3_data_chip_enable_n[0] == l3_data_chip_enable_n[1]; endproperty
   a_ce: assert property (p_ce) else $error("chip enable copies differ");
   property p_toe; l3_tag_output_enable_n; endproperty
   a_toe: assert property (p_toe) else $error("tag output enable used");
   c_wr: cover property (!outbound_valid_n && command_id_bus_out == 9'h100);
   c_rd: cover property (!outbound_valid_n && command_id_bus_out == 9'h000);
   c_rel: cover property ($fell(release_n));
endmodule
bind sbtc_core sbtc_core_assertions chk_u (.*);
`default_nettype wire

// ==== sbtc_agent_model.sv ====
// Behavioural system agent: returns four words per released read.
// Assumes the bench drives stall and slow on the same clock.
`timescale 1ns/100ps
`default_nettype none
module sbtc_agent_model (
   // Clock, reset
   input wire logic clk,
   input wire logic rst_n,
   // Bench knobs
   input wire logic slow,
   input wire logic stall,
   // Processor pins
   input wire logic release_n,
   input wire logic outbound_valid_n,
   input wire logic [8:0] command_id_bus_out,
   // Agent pins
   output logic read_accept_n,
   output logic write_accept_n,
   output logic inbound_valid_n,
   output logic [63:0] bus_in,
   output logic [7:0] par_in
);
   int pend;
   int left;
   logic [31:0] wk;
   logic [63:0] w;
   // ====================
   // Handshakes and read return
   assign w = {wk, ~wk};
   assign read_accept_n = stall;
   assign write_accept_n = stall;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {pend, left, wk, bus_in, par_in} <= '0;
         inbound_valid_n <= 1'b1;
      end else begin
         if (!outbound_valid_n && command_id_bus_out[8:7] == 2'b00)
            pend <= pend + 1;
         if (!release_n && pend > 0) begin
            left <= 4 * pend;
            pend <= 0;
         end
         // Slow mode leaves a gap after every word
         if (left > 0 && !(slow && !inbound_valid_n)) begin
            inbound_valid_n <= 1'b0;
            bus_in <= w;
            for (int i = 0; i < 8; i++)
               par_in[i] <= ^w[8*i+:8];
            wk <= wk + 1;
            left <= left - 1;
         end else begin
            // Released lines must not keep the last word
            inbound_valid_n <= 1'b1;
            bus_in <= ~bus_in;
            par_in <= ~par_in;
         end
      end
   end
endmodule
`default_nettype wire

// ==== sbtc_core_test.sv ====
// Random bench for sbtc_core against a behavioural agent.
// Assumes the agent model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module sbtc_core_test;
   logic clk, rst_n, mode_two_reads, mode_l3_enable, req_valid, req_ready, req_write, req_instr, rsp_valid;
   logic rsp_ready, rsp_slot, l3_clear_req, par_err_clear, par_err, agent_request_n, release_n, read_kind;
   logic read_accept_n, write_accept_n, inbound_valid_n, outbound_valid_n, cpu_bus_request_n;
   logic cpu_bus_grant_n, return_order_swap_n, shared_addr_data_bus_oe, shared_bus_parity_oe;
   logic command_id_bus_oe, command_bus_parity_in, command_bus_parity_out, command_bus_parity_oe;
   logic l3_block_clear_n, l3_data_output_enable_n, l3_tag_hit, l3_tag_chip_enable_n, l3_tag_latch_enable_n;
   logic l3_tag_output_enable_n, l3_doubleword_index_oe, l3_line_valid_in, l3_line_valid_out, l3_line_valid_oe;
   logic [63:0] req_addr, req_wdata, rsp_data, shared_addr_data_bus_in, shared_addr_data_bus_out;
   logic [7:0] shared_bus_parity_in, shared_bus_parity_out;
   logic [8:0] command_id_bus_in, command_id_bus_out;
   logic [1:0] l3_write_enable_n, l3_data_chip_enable_n, l3_doubleword_index_in, l3_doubleword_index_out;
   logic [17:0] l3_line_index;
   logic [31:0] seed, noise, ek;
   logic slow, stall;
   int mismatches, n_checks, clears, probes, rels;
   sbtc_core dut_u (.*);
   sbtc_agent_model agent_u (.clk, .rst_n, .slow, .stall, .release_n, .outbound_valid_n, .command_id_bus_out,
      .read_accept_n, .write_accept_n, .inbound_valid_n, .bus_in(shared_addr_data_bus_in),
      .par_in(shared_bus_parity_in));
   // ====================
   // Helpers
   function automatic logic [31:0] rnd(inout logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Ignored inputs get noise; return side stalls at random
   always @(posedge clk)
      {rsp_ready, command_id_bus_in, command_bus_parity_in, l3_doubleword_index_in, l3_line_valid_in} <= 14'(rnd(noise));
   always @(negedge clk) begin
      clears += !l3_block_clear_n;
      probes += !l3_tag_chip_enable_n;
      rels += !release_n;
   end
   initial begin
      #100000;
      mismatches++;
      end_sim();
   end
   // ====================
   // One request, checked on the pins
   task automatic op(input logic wr);
      logic [31:0] r;
      r = rnd(seed);
      stall <= r[2];
      slow <= r[1];
      repeat (4) @(posedge clk);
      if (r[2]) check(req_ready, 1'b0);
      stall <= 1'b0;
      req_write <= wr;
      req_instr <= r[0];
      req_addr <= {rnd(seed), r};
      req_wdata <= {r, rnd(seed)};
      req_valid <= 1'b1;
      @(posedge clk);
      repeat (300) if (!req_ready) @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
      check(outbound_valid_n, 1'b0);
      check(shared_addr_data_bus_out, req_addr);
      check(command_id_bus_out & 9'h1fe, wr ? 9'h080 : 9'h000);
      if (wr) begin
         @(negedge clk);
         check(shared_addr_data_bus_out, req_wdata);
         check(command_id_bus_out, 9'h100);
      end else begin
         check(read_kind, r[0]);
         check(l3_tag_chip_enable_n, !mode_l3_enable);
         if (mode_l3_enable) check(l3_line_index, req_addr[22:5]);
         repeat (4) begin
            @(posedge clk);
            repeat (300) if (!(rsp_valid && rsp_ready)) @(posedge clk);
            check(rsp_data, {ek, ~ek});
            ek++;
         end
      end
   endtask
   initial begin
      {rst_n, req_valid, req_write, req_instr, l3_clear_req, par_err_clear, slow, stall} = '0;
      {mode_two_reads, mode_l3_enable, l3_tag_hit, req_addr, req_wdata, mismatches, n_checks} = '0;
      {agent_request_n, cpu_bus_grant_n, return_order_swap_n, l3_data_output_enable_n} = '1;
      {rsp_ready, command_id_bus_in, command_bus_parity_in, l3_doubleword_index_in, l3_line_valid_in} = '0;
      seed = 32'h9ac5_0983;
      noise = 32'h9ac5_0983;
      for (int ph = 0; ph < 2; ph++) begin
         rst_n <= 1'b0;
         mode_l3_enable <= ph[0];
         repeat (16) @(posedge clk);
         {clears, probes, ek, rels} = '0;
         rst_n <= 1'b1;
         repeat (4) @(posedge clk);
         check(rels, 0);
         l3_clear_req <= 1'b1;
         @(posedge clk);
         l3_clear_req <= 1'b0;
         for (int i = 0; i < 16; i++)
            op(i[0]);
         @(posedge clk);
         rels = 0;
         agent_request_n <= 1'b0;
         repeat (20) @(posedge clk);
         agent_request_n <= 1'b1;
         repeat (8) @(posedge clk);
         check(rels, 1);
         check(clears, ph);
         check(probes != 0, ph);
         check(par_err, 1'b0);
         check(cpu_bus_request_n, 1'b1);
      end
      end_sim();
   end
endmodule
`default_nettype wire
